// ===== logic/palette_port_pkg.sv
// constants and carriers for the palette index front end
// assumes byte-wide host i/o strobes on the display clock
package palette_port_pkg;
    localparam logic [15:0] mask_addr = 16'h03c6;
    localparam logic [15:0] state_addr = 16'h03c7;
    localparam logic [15:0] rdptr_addr = 16'h03c7;
    localparam logic [15:0] wrptr_addr = 16'h03c8;
    localparam logic [15:0] data_addr = 16'h03c9;
    localparam logic [1:0] last_wrote_write = 2'h0;
    localparam logic [1:0] last_wrote_read = 2'h3;
    localparam logic [7:0] pointer_reset = 8'h00;
    localparam logic [7:0] mask_reset = 8'h00;
    localparam logic [1:0] phase_reset = 2'h0;
    localparam int field_lsb = 0;

    typedef enum logic [1:0] {ph_red, ph_green, ph_blue} phase_t;

    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } io_req_t;

    typedef struct packed {
        logic we;
        logic [7:0] index;
        logic [23:0] rgb;
    } pal_wr_t;
endpackage : palette_port_pkg

// ===== logic/pixel_mask_stage.sv
// pixel index masking stage
// assumes pixel data on the same clock as the block
`timescale 1ns/1ns
module pixel_mask_stage #(
    parameter int width = 8
) (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // pixel path
    input wire logic [width-1:0] pixel_in,
    input wire logic pixel_valid,
    input wire logic [width-1:0] mask,
    output logic [width-1:0] index_out,
    output logic index_valid
);
    typedef struct packed {
        logic [width-1:0] idx;
        logic vld;
    } st_t;
    st_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        s_d.vld = pixel_valid;
        s_d.idx = pixel_in & mask; // [RULE1] [RULE2]
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign index_out = s_q.idx;
    assign index_valid = s_q.vld;

    mask_zero_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        pixel_valid |=> ((index_out & ~$past(mask)) == '0)) // [RULE2]
        else $error("masked bit leaked");
    mask_pass_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        pixel_valid |=> (index_out == ($past(pixel_in) & $past(mask)))) // [RULE1]
        else $error("index not pixel and mask");
endmodule : pixel_mask_stage

// ===== logic/vga_palette_index_port.sv
// palette index port: mask, state, read/write pointers and rgb sequencer
// assumes host i/o strobes and pixel data are synchronous to ref_clk;
// palette storage sits outside and answers pal_rdata combinationally from pal_rd_index
//
// Summary of operation
// RULE1: pixel AND mask gives palette index
// RULE2: mask zero clears bit, one passes
// RULE3: state register bits 7:2 read zero
// RULE4: two-bit field records last written pointer
// RULE5: 00 after reset/write pointer, 11 read
// RULE6: read pointer write selects entry read
// RULE7: read pointer increments after three reads
// RULE8: read pointer write aborts partial write
// RULE9: palette reads work in any mode
// RULE10: data port steps red, green, blue
// RULE11: pointer write resets rgb sequencer
// RULE12: entry updated after three writes, increments
// RULE13: shared address reads state, writes pointer
// RULE14: host programs mask before indexed display
`timescale 1ns/1ns
module vga_palette_index_port (
    // clock and reset
    input wire logic ref_clk,
    input wire logic reset_n,
    // host i/o
    input wire palette_port_pkg::io_req_t io_req,
    output logic [7:0] io_rdata,
    // pixel path
    input wire logic [7:0] pixel_in,
    input wire logic pixel_valid,
    output logic [7:0] pixel_index,
    output logic pixel_index_valid,
    // palette storage
    output logic [7:0] pal_rd_index,
    input wire logic [23:0] pal_rdata,
    output palette_port_pkg::pal_wr_t pal_wr
);
    typedef struct packed {
        logic [7:0] mask;
        logic [1:0] last;
        logic [7:0] rptr;
        logic [7:0] wptr;
        palette_port_pkg::phase_t phase;
        logic [15:0] held;
        logic [7:0] rdata;
        palette_port_pkg::pal_wr_t wr;
    } st_t;
    st_t s_q, s_d;

    logic rd_data, wr_data, wr_rptr, wr_wptr;
    logic [7:0] byte_sel;

    assign rd_data = io_req.rd && io_req.addr == palette_port_pkg::data_addr;
    assign wr_data = io_req.wr && io_req.addr == palette_port_pkg::data_addr;
    assign wr_rptr = io_req.wr && io_req.addr == palette_port_pkg::rdptr_addr; // [RULE13]
    assign wr_wptr = io_req.wr && io_req.addr == palette_port_pkg::wrptr_addr;

    // ------------------------------------------------------------
    // rgb component select
    // ------------------------------------------------------------
    always_comb begin
        case (s_q.phase)
            palette_port_pkg::ph_red: byte_sel = pal_rdata[23:16]; // [RULE10]
            palette_port_pkg::ph_green: byte_sel = pal_rdata[15:8];
            palette_port_pkg::ph_blue: byte_sel = pal_rdata[7:0];
            default: byte_sel = 8'h00;
        endcase
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    always_comb begin
        s_d = s_q;
        s_d.wr.we = 1'b0;
        if (io_req.wr && io_req.addr == palette_port_pkg::mask_addr) begin
            s_d.mask = io_req.wdata;
        end
        if (io_req.rd) begin
            if (io_req.addr == palette_port_pkg::mask_addr) begin
                s_d.rdata = s_q.mask;
            end else if (io_req.addr == palette_port_pkg::state_addr) begin
                s_d.rdata = {6'h00, s_q.last}; // [RULE3] [RULE4] [RULE13]
            end else if (rd_data) begin
                s_d.rdata = byte_sel; // [RULE9]
            end else begin
                s_d.rdata = 8'h00;
            end
        end
        if (wr_rptr) begin
            s_d.rptr = io_req.wdata; // [RULE6]
            s_d.last = palette_port_pkg::last_wrote_read; // [RULE5]
            s_d.phase = palette_port_pkg::ph_red; // [RULE8] [RULE11]
        end else if (wr_wptr) begin
            s_d.wptr = io_req.wdata;
            s_d.last = palette_port_pkg::last_wrote_write; // [RULE5]
            s_d.phase = palette_port_pkg::ph_red; // [RULE11]
        end else if (rd_data || wr_data) begin
            case (s_q.phase)
                palette_port_pkg::ph_red: begin
                    s_d.phase = palette_port_pkg::ph_green; // [RULE10]
                    if (wr_data) s_d.held[15:8] = io_req.wdata;
                end
                palette_port_pkg::ph_green: begin
                    s_d.phase = palette_port_pkg::ph_blue;
                    if (wr_data) s_d.held[7:0] = io_req.wdata;
                end
                palette_port_pkg::ph_blue: begin
                    s_d.phase = palette_port_pkg::ph_red;
                    if (wr_data) begin
                        s_d.wr.we = 1'b1; // [RULE12]
                        s_d.wr.index = s_q.wptr;
                        s_d.wr.rgb = {s_q.held, io_req.wdata};
                        s_d.wptr = s_q.wptr + 8'h01;
                    end else begin
                        s_d.rptr = s_q.rptr + 8'h01; // [RULE7]
                    end
                end
                default: s_d.phase = palette_port_pkg::ph_red;
            endcase
        end
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            s_q <= '0;
            s_q.mask <= palette_port_pkg::mask_reset;
            s_q.last <= palette_port_pkg::last_wrote_write; // [RULE5]
            s_q.rptr <= palette_port_pkg::pointer_reset;
            s_q.wptr <= palette_port_pkg::pointer_reset;
            s_q.phase <= palette_port_pkg::ph_red;
        end else begin
            s_q <= s_d;
        end
    end

    assign io_rdata = s_q.rdata;
    assign pal_rd_index = s_q.rptr;
    assign pal_wr = s_q.wr;

    pixel_mask_stage #(
        .width(8)
    ) u_mask (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .pixel_in(pixel_in),
        .pixel_valid(pixel_valid),
        .mask(s_q.mask), // [RULE14]
        .index_out(pixel_index),
        .index_valid(pixel_index_valid)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence three_reads_s;
        rd_data && !wr_rptr ##1 (!io_req.wr)[*1] ##0 rd_data ##1 rd_data;
    endsequence

    state_upper_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (io_req.rd && io_req.addr == palette_port_pkg::state_addr)
        |=> io_rdata[7:2] == 6'h00) // [RULE3]
        else $error("state upper bits not zero");
    last_read_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        wr_rptr |=> s_q.last == 2'h3) // [RULE5]
        else $error("last field not 11");
    last_write_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (wr_wptr && !wr_rptr) |=> s_q.last == 2'h0) // [RULE5]
        else $error("last field not 00");
    last_legal_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        s_q.last == 2'h0 || s_q.last == 2'h3) // [RULE4]
        else $error("reserved last code");
    rptr_load_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        wr_rptr |=> pal_rd_index == $past(io_req.wdata)) // [RULE6]
        else $error("read pointer not loaded");
    rptr_step_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (s_q.phase == palette_port_pkg::ph_blue && rd_data && !io_req.wr)
        |=> pal_rd_index == $past(pal_rd_index) + 8'h01) // [RULE7]
        else $error("read pointer not stepped");
    abort_write_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        wr_rptr |=> !pal_wr.we ##1 (s_q.phase == palette_port_pkg::ph_red
        || !pal_wr.we)) // [RULE8]
        else $error("aborted write committed");
    seq_reset_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (wr_rptr || wr_wptr) |=> s_q.phase == palette_port_pkg::ph_red) // [RULE11]
        else $error("sequencer not reset");
    commit_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        pal_wr.we |-> $past(wr_data) && $past(s_q.phase) == palette_port_pkg::ph_blue
        && s_q.wptr == pal_wr.index + 8'h01) // [RULE12]
        else $error("commit without third byte");
    rgb_order_a: assert property (@(posedge ref_clk) disable iff (!reset_n)
        (s_q.phase == palette_port_pkg::ph_red && rd_data && !io_req.wr)
        |=> io_rdata == $past(pal_rdata[23:16])) // [RULE10] [RULE9]
        else $error("first read not red");
endmodule : vga_palette_index_port

// ===== testbench/palette_store_model.sv
// palette storage stand-in for the index port
// assumes commits arrive as a one-cycle we pulse on ref_clk
`timescale 1ns/1ns
module palette_store_model (
    // clock
    input wire logic ref_clk,
    // storage side
    input wire logic [7:0] rd_index,
    output logic [23:0] rdata,
    input wire palette_port_pkg::pal_wr_t wr
);
    logic [23:0] mem [256];
    initial begin
        for (int i = 0; i < 256; i++) begin
            mem[i] = 24'(i * 24'h010305) ^ 24'h5a5a5a;
        end
    end
    assign rdata = mem[rd_index];
    always @(posedge ref_clk) begin
        if (wr.we) begin
            mem[wr.index] <= wr.rgb;
        end
    end
endmodule : palette_store_model

// ===== testbench/tb_vga_palette_index_port.sv
// self-checking bench for the palette index port
// assumes storage answers combinationally from pal_rd_index
`timescale 1ns/1ns
module tb_vga_palette_index_port;
    logic ref_clk, reset_n, pixel_valid, pixel_index_valid;
    logic [7:0] pixel_in, pixel_index, io_rdata, pal_rd_index, pix;
    logic [23:0] pal_rdata;
    palette_port_pkg::io_req_t io_req;
    palette_port_pkg::pal_wr_t pal_wr;
    palette_port_pkg::pal_wr_t wq [$];
    int err_total = 0, samples_checked = 0, rptr = 0, wptr = 0, ph = 0, last = 0, msk = 0;
    logic [23:0] mem [256];
    logic [7:0] part [3];
    logic [15:0] rnd = 16'h662d;

    vga_palette_index_port vga_palette_index_port_i (.ref_clk(ref_clk), .reset_n(reset_n),
        .io_req(io_req), .io_rdata(io_rdata), .pixel_in(pixel_in), .pixel_valid(pixel_valid),
        .pixel_index(pixel_index), .pixel_index_valid(pixel_index_valid),
        .pal_rd_index(pal_rd_index), .pal_rdata(pal_rdata), .pal_wr(pal_wr));
    palette_store_model palette_store_model_i (.ref_clk(ref_clk), .rd_index(pal_rd_index),
        .rdata(pal_rdata), .wr(pal_wr));

    function automatic logic [15:0] lfsr(logic [15:0] x);
        return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
    endfunction : lfsr
    task automatic check_byte(logic [7:0] got, logic [7:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t byte %h want %h", $time, got, exp);
        end
    endtask : check_byte
    task automatic check_commit(palette_port_pkg::pal_wr_t got, palette_port_pkg::pal_wr_t exp);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t commit %h want %h", $time, got, exp);
        end
    endtask : check_commit
    task automatic host_wr(logic [15:0] a, logic [7:0] d);
        @(negedge ref_clk);
        io_req <= {1'b0, 1'b1, a, d};
        @(negedge ref_clk);
        io_req.wr <= 1'b0;
        if (a == 16'h03c6) msk = d;
        if (a == 16'h03c7 || a == 16'h03c8) ph = 0;
        if (a == 16'h03c7) rptr = d;
        if (a == 16'h03c7) last = 3;
        if (a == 16'h03c8) wptr = d;
        if (a == 16'h03c8) last = 0;
        if (a == 16'h03c9) begin
            part[ph] = d;
            ph++;
        end
        if (ph == 3) begin
            mem[wptr] = {part[0], part[1], part[2]};
            wq.push_back({1'b1, 8'(wptr), mem[wptr]});
            wptr = (wptr + 1) % 256;
            ph = 0;
        end
    endtask : host_wr
    task automatic host_rd(logic [15:0] a);
        logic [7:0] e;
        e = 8'h00;
        @(negedge ref_clk);
        io_req <= {1'b1, 1'b0, a, 8'h00};
        @(negedge ref_clk);
        io_req.rd <= 1'b0;
        if (a == 16'h03c6) e = 8'(msk);
        if (a == 16'h03c7) e = 8'(last);
        if (a == 16'h03c9) begin
            e = mem[rptr][23 - 8 * ph -: 8];
            ph++;
        end
        if (ph == 3) begin
            rptr = (rptr + 1) % 256;
            ph = 0;
        end
        check_byte(io_rdata, e);
        check_byte(pal_rd_index, 8'(rptr));
    endtask : host_rd
    task automatic give_verdict;
        $display("checked %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    always @(posedge ref_clk) begin
        if (pal_wr.we === 1'b1) begin
            check_commit(pal_wr, wq.size() > 0 ? wq.pop_front() : '0);
        end
    end
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    initial begin
        #(40 * 6000);
        err_total++;
        give_verdict();
    end
    initial begin
        for (int i = 0; i < 256; i++) mem[i] = 24'(i * 24'h010305) ^ 24'h5a5a5a;
        reset_n = 1'b0;
        io_req = '0;
        pixel_in = 8'h00;
        pixel_valid = 1'b0;
        repeat (20) @(negedge ref_clk);
        reset_n = 1'b1;
        host_rd(16'h03c7);
        host_rd(16'h03c5);
        $display("done: reset state");
        for (int m = 0; m < 3; m++) begin
            rnd = lfsr(rnd);
            host_wr(16'h03c6, m == 0 ? 8'h00 : m == 1 ? 8'hff : rnd[15:8]);
            host_rd(16'h03c6);
            for (int i = 0; i < 17; i++) begin
                rnd = lfsr(rnd);
                @(negedge ref_clk);
                if (i > 0) check_byte(pixel_index, pix & 8'(msk));
                if (i > 0) check_byte({7'h00, pixel_index_valid}, 8'h01);
                pix = rnd[7:0];
                pixel_in <= pix;
                pixel_valid <= 1'b1;
            end
            @(negedge ref_clk);
            check_byte(pixel_index, pix & 8'(msk));
            pixel_valid <= 1'b0;
            @(negedge ref_clk);
            check_byte({7'h00, pixel_index_valid}, 8'h00);
        end
        $display("done: pixel mask");
        host_wr(16'h03c7, 8'hfe);
        host_rd(16'h03c7);
        repeat (6) host_rd(16'h03c9);
        host_wr(16'h03c8, 8'h10);
        host_rd(16'h03c7);
        repeat (3) host_wr(16'h03c9, 8'(lfsr(rnd)));
        host_wr(16'h03c8, 8'h20);
        repeat (2) host_wr(16'h03c9, 8'haa);
        host_wr(16'h03c7, 8'h20);
        host_rd(16'h03c9);
        host_wr(16'h03c7, 8'h10);
        repeat (3) host_rd(16'h03c9);
        $display("done: directed pointers");
        @(negedge ref_clk);
        reset_n = 1'b0;
        repeat (2) @(negedge ref_clk);
        reset_n = 1'b1;
        rptr = 0;
        wptr = 0;
        ph = 0;
        last = 0;
        msk = 0;
        part[0] = 8'h00;
        part[1] = 8'h00;
        host_rd(16'h03c7);
        host_rd(16'h03c6);
        $display("done: mid-run reset");
        for (int i = 0; i < 300; i++) begin
            rnd = lfsr(rnd);
            if (rnd[2]) host_wr(16'h03c6 + 16'(rnd[1:0]), rnd[15:8]);
            else host_rd(rnd[1] ? 16'h03c9 : 16'h03c6 + 16'(rnd[0]));
        end
        repeat (2) @(negedge ref_clk);
        check_byte(8'(wq.size()), 8'h00);
        $display("done: random traffic");
        give_verdict();
    end
endmodule : tb_vga_palette_index_port
